// ---- verilog/esc_top.v ----
// Eye-scan control top: register port, reset synchroniser, sampler settings and two lanes.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "esc_regs.vh"
module esc_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Register port
    input wire [9:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Sampler bits, one per lane
    input wire [1:0] data_bit_i,
    input wire [1:0] scan_bit_i,
    // Scan sampler steering
    output reg [6:0] phase_shift_o,
    output reg [5:0] thresh_shift_o
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    reg [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // Sampler inputs arrive from the analog front end, so synchronise.
    // ------------------------------------------------------------------
    reg [1:0] dat_s1_r;
    reg [1:0] dat_s2_r;
    reg [1:0] scn_s1_r;
    reg [1:0] scn_s2_r;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dat_s1_r <= 2'b00;
            dat_s2_r <= 2'b00;
            scn_s1_r <= 2'b00;
            scn_s2_r <= 2'b00;
        end else begin
            dat_s1_r <= data_bit_i;
            dat_s2_r <= dat_s1_r;
            scn_s1_r <= scan_bit_i;
            scn_s2_r <= scn_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [7:0] run_reg_r;
    reg [7:0] setup_r;
    reg [7:0] phase_r;
    reg [7:0] thresh_r;
    reg [7:0] slot_r;
    reg [7:0] wipe_r;
    reg run_d_r;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_reg_r <= `ESC_RST_BYTE;
            setup_r <= `ESC_RST_BYTE;
            phase_r <= `ESC_RST_BYTE;
            thresh_r <= `ESC_RST_BYTE;
            slot_r <= `ESC_RST_BYTE;
            wipe_r <= `ESC_RST_BYTE;
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_reg_r[0];
            if (wr_i) begin
                if (addr_i == `ESC_OFF_RUN) begin
                    run_reg_r <= wdata_i;
                end else if (addr_i == `ESC_OFF_SETUP) begin
                    setup_r <= wdata_i;
                end else if (addr_i == `ESC_OFF_PHASE) begin
                    phase_r <= wdata_i;
                end else if (addr_i == `ESC_OFF_THRESH) begin
                    thresh_r <= wdata_i;
                end else if (addr_i == `ESC_OFF_SLOT) begin
                    slot_r <= wdata_i;
                end else if (addr_i == `ESC_OFF_WIPE) begin
                    wipe_r <= wdata_i;
                end
            end
        end
    end

    wire run_w = run_reg_r[0];
    wire start_w = run_w && !run_d_r;
    wire [3:0] mode_w = setup_r[`ESC_MODE_MSB:`ESC_MODE_LSB];
    wire [1:0] len_code_w = setup_r[`ESC_LEN_MSB:`ESC_LEN_LSB];
    // Settings are used live; software keeps them still while running.
    reg [15:0] len_w;
    always @* begin
        case (len_code_w)
            2'd0: len_w = `ESC_LEN0;
            2'd1: len_w = `ESC_LEN1;
            2'd2: len_w = `ESC_LEN2;
            default: len_w = `ESC_LEN3;
        endcase
    end

    // Wipe acts on the falling edge of the wipe bit, i.e. after 1 then 0.
    reg wipe_d_r;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wipe_d_r <= 1'b0;
        end else begin
            wipe_d_r <= wipe_r[0];
        end
    end
    wire wipe_w = wipe_d_r && !wipe_r[0];

    // ------------------------------------------------------------------
    // Lanes
    // ------------------------------------------------------------------
    wire pick_w;
    esc_slot_pick u_pick (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i(run_w),
        .slot_i(slot_r[4:0]),
        .pick_o(pick_w)
    );

    wire [1:0] done_w;
    wire [15:0] tally_w [0:1];
    wire [5:0] found_w [0:1];
    wire [5:0] probe_w [0:1];
    genvar g;
    generate
        for (g = 0; g < `ESC_LANES; g = g + 1) begin : g_lane
            esc_lane u_lane (
                .clk_i(clk_i),
                .rst_n_i(rst_n),
                .run_i(run_w),
                .start_i(start_w),
                .wipe_i(wipe_w),
                .mode_i(mode_w),
                .len_i(len_w),
                .pick_i(pick_w),
                .data_bit_i(dat_s2_r[g]),
                .scan_bit_i(scn_s2_r[g]),
                .done_o(done_w[g]),
                .tally_o(tally_w[g]),
                .found_o(found_w[g]),
                .probe_o(probe_w[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sampler steering and read data
    // ------------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase_shift_o <= 7'h00;
            thresh_shift_o <= 6'h00;
            rdata_o <= 8'h00;
        end else begin
            phase_shift_o <= phase_r[6:0];
            // Search modes drive lane 0's probe; each lane sweeps on its own qualified samples.
            thresh_shift_o <= mode_w[3] ? probe_w[0] : thresh_r[5:0];
            rdata_o <= 8'h00;
            if (rd_i) begin
                if (addr_i == `ESC_OFF_RUN) begin
                    rdata_o <= run_reg_r;
                end else if (addr_i == `ESC_OFF_SETUP) begin
                    rdata_o <= setup_r;
                end else if (addr_i == `ESC_OFF_PHASE) begin
                    rdata_o <= phase_r;
                end else if (addr_i == `ESC_OFF_THRESH) begin
                    rdata_o <= thresh_r;
                end else if (addr_i == `ESC_OFF_SLOT) begin
                    rdata_o <= slot_r;
                end else if (addr_i == `ESC_OFF_WIPE) begin
                    rdata_o <= wipe_r;
                end else if (addr_i == `ESC_OFF_DONE_LO) begin
                    rdata_o <= {6'h00, done_w};
                end else if (addr_i == `ESC_OFF_FOUND) begin
                    rdata_o <= {2'b00, found_w[0]};
                end else if (addr_i == `ESC_OFF_FOUND + 10'h001) begin
                    rdata_o <= {2'b00, found_w[1]};
                end else if (addr_i == `ESC_OFF_TALLY_LO) begin
                    rdata_o <= tally_w[0][7:0];
                end else if (addr_i == `ESC_OFF_TALLY_LO + 10'h001) begin
                    rdata_o <= tally_w[0][15:8];
                end else if (addr_i == `ESC_OFF_TALLY_HI) begin
                    rdata_o <= tally_w[1][7:0];
                end else if (addr_i == `ESC_OFF_TALLY_HI + 10'h001) begin
                    rdata_o <= tally_w[1][15:8];
                end
            end
        end
    end
endmodule

// ---- verilog/esc_regs.vh ----
// Register offsets, field positions, reset values and scan constants for the eye-scan control.
`ifndef ESC_REGS_VH
`define ESC_REGS_VH
`define ESC_ADDR_W 10
`define ESC_OFF_RUN 10'h1f0
`define ESC_OFF_SETUP 10'h1f1
`define ESC_OFF_PHASE 10'h1f2
`define ESC_OFF_THRESH 10'h1f3
`define ESC_OFF_SLOT 10'h1f4
`define ESC_OFF_WIPE 10'h1f5
`define ESC_OFF_DONE_LO 10'h1f6
`define ESC_OFF_DONE_HI 10'h1f7
`define ESC_OFF_FOUND 10'h200
`define ESC_OFF_TALLY_LO 10'h210
`define ESC_OFF_TALLY_HI 10'h212
`define ESC_RST_BYTE 8'h00
`define ESC_MODE_LSB 0
`define ESC_MODE_MSB 3
`define ESC_LEN_LSB 4
`define ESC_LEN_MSB 5
`define ESC_LEN0 16'd127
`define ESC_LEN1 16'd1032
`define ESC_LEN2 16'd8191
`define ESC_LEN3 16'd65535
`define ESC_MODE_OFF 4'h0
`define ESC_MODE_CMP 4'h1
`define ESC_MODE_CMP0 4'h2
`define ESC_MODE_CMP1 4'h3
`define ESC_MODE_ONES 4'h4
`define ESC_MODE_AVG0 4'h8
`define ESC_MODE_OUT0 4'h9
`define ESC_MODE_IN0 4'ha
`define ESC_MODE_AVG1 4'hc
`define ESC_MODE_OUT1 4'hd
`define ESC_MODE_IN1 4'he
`define ESC_GROUP_LAST 5'h13
`define ESC_LANES 2
`endif

// ---- verilog/esc_slot_pick.v ----
// Bit-slot selector: picks one sample of every 20-bit group for the scan.
`timescale 1ns/1ps
`include "esc_regs.vh"
module esc_slot_pick (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Control
    input wire run_i,
    input wire [4:0] slot_i,
    // Strobe
    output reg pick_o
);
    reg [4:0] pos_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_r <= 5'h00;
            pick_o <= 1'b0;
        end else if (!run_i) begin
            pos_r <= 5'h00;
            pick_o <= 1'b0;
        end else begin
            // Slots above 19 never match, so such a scan just stays idle.
            pick_o <= (pos_r == slot_i);
            pos_r <= (pos_r == `ESC_GROUP_LAST) ? 5'h00 : pos_r + 5'h01;
        end
    end
endmodule

// ---- verilog/esc_lane.v ----
// One lane's scan engine: qualified sample counter, tally and threshold search.
`timescale 1ns/1ps
`include "esc_regs.vh"
module esc_lane (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Control
    input wire run_i,
    input wire start_i,
    input wire wipe_i,
    input wire [3:0] mode_i,
    input wire [15:0] len_i,
    input wire pick_i,
    // Samplers
    input wire data_bit_i,
    input wire scan_bit_i,
    // Results
    output reg done_o,
    output reg [15:0] tally_o,
    output reg [5:0] found_o,
    output reg [5:0] probe_o
);
    reg [15:0] seen_r;
    reg [15:0] hits_r;
    reg [5:0] lo_r;
    reg [5:0] hi_r;
    reg any_r;
    wire auto_w = mode_i[3];
    wire want_w = mode_i[2];
    // Search modes chase zeros for 8..10 and ones for 12..14.
    wire qual_w = (mode_i == `ESC_MODE_CMP0 || (auto_w && !want_w)) ? !data_bit_i :
                  (mode_i == `ESC_MODE_CMP1 || (auto_w && want_w)) ? data_bit_i : 1'b1;
    wire take_w = run_i && !done_o && pick_i && (mode_i != `ESC_MODE_OFF) && qual_w;
    wire match_w = (scan_bit_i == want_w);
    wire [6:0] sum_w = {lo_r[5], lo_r} + {hi_r[5], hi_r};
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_r <= 16'h0000;
            tally_o <= 16'h0000;
            done_o <= 1'b0;
            found_o <= 6'h00;
            probe_o <= 6'h00;
            lo_r <= 6'h1f;
            hi_r <= 6'h20;
            any_r <= 1'b0;
            hits_r <= 16'h0000;
        end else if (start_i) begin
            seen_r <= 16'h0000;
            done_o <= 1'b0;
            probe_o <= 6'h20;
            lo_r <= 6'h1f;
            hi_r <= 6'h20;
            any_r <= 1'b0;
            hits_r <= 16'h0000;
            if (wipe_i) begin
                tally_o <= 16'h0000;
            end
        end else begin
            if (wipe_i) begin
                tally_o <= 16'h0000;
            end else if (take_w && !auto_w) begin
                if (mode_i == `ESC_MODE_ONES) begin
                    if (scan_bit_i) begin
                        tally_o <= tally_o + 16'h0001;
                    end
                end else if (scan_bit_i != data_bit_i) begin
                    tally_o <= tally_o + 16'h0001;
                end
            end
            if (take_w) begin
                seen_r <= seen_r + 16'h0001;
                if (seen_r + 16'h0001 == len_i) begin
                    done_o <= 1'b1;
                end
            end
            // Auto search sweeps the threshold one step per full sample budget.
            if (take_w && auto_w) begin
                if (match_w) begin
                    hits_r <= hits_r + 16'h0001;
                end
                if (seen_r + 16'h0001 == len_i) begin
                    if (match_w || hits_r != 16'h0000) begin
                        any_r <= 1'b1;
                        if (!any_r || $signed(probe_o) < $signed(lo_r)) begin
                            lo_r <= probe_o;
                        end
                        if (!any_r || $signed(probe_o) > $signed(hi_r)) begin
                            hi_r <= probe_o;
                        end
                    end
                    if (probe_o != 6'h1f) begin
                        done_o <= 1'b0;
                        seen_r <= 16'h0000;
                        hits_r <= 16'h0000;
                        probe_o <= probe_o + 6'h01;
                    end
                end
            end
            if (done_o && auto_w) begin
                // Result stands once done, so assign only on the done edge.
                found_o <= found_o;
            end
            if (take_w && auto_w && seen_r + 16'h0001 == len_i && probe_o == 6'h1f) begin
                if (mode_i == `ESC_MODE_AVG0 || mode_i == `ESC_MODE_AVG1) begin
                    found_o <= sum_w[6:1];
                end else if (mode_i == `ESC_MODE_OUT0 || mode_i == `ESC_MODE_IN1) begin
                    found_o <= lo_r;
                end else begin
                    found_o <= hi_r;
                end
            end
        end
    end
endmodule

// ---- sim/esc_top_chk.sv ----
// Port-level assertions for the eye-scan control top.
`timescale 1ns/1ps
module esc_top_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Register port
    input wire [9:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // Samplers and steering
    input wire [1:0] data_bit_i,
    input wire [1:0] scan_bit_i,
    input wire [6:0] phase_shift_o,
    input wire [5:0] thresh_shift_o
);
    // Shadow of the writable bytes 0x1f0..0x1f5, and cycles since the run bit rose.
    logic [7:0] shd_r [0:5];
    logic [5:0] age_r;
    wire wr_ctl = wr_i && addr_i >= 10'h1f0 && addr_i <= 10'h1f5;
    wire run_up = wr_i && addr_i == 10'h1f0 && wdata_i[0] && !shd_r[0][0];
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 6; i++)
                shd_r[i] <= 8'h00;
            age_r <= 6'h3f;
        end else begin
            if (wr_ctl)
                shd_r[addr_i[2:0]] <= wdata_i;
            if (run_up)
                age_r <= 6'h00;
            else if (age_r != 6'h3f)
                age_r <= age_r + 6'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_follow_ph;
        wr_i && addr_i == 10'h1f2 |-> ##2 phase_shift_o == $past(wdata_i[6:0], 2);
    endproperty
    property p_follow_th;
        wr_i && addr_i == 10'h1f3 && !shd_r[1][3]
            |-> ##2 thresh_shift_o == $past(wdata_i[5:0], 2);
    endproperty
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    a_ctl_readback: assert property (rd_i && addr_i >= 10'h1f0 && addr_i <= 10'h1f5
        |=> rdata_o == $past(shd_r[addr_i[2:0]])) else $error("control byte readback wrong");
    a_unmapped_zero: assert property (rd_i && !(addr_i inside {[10'h1f0:10'h1f7], 10'h200,
        10'h201, [10'h210:10'h213]}) |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_done_hi_zero: assert property (rd_i && addr_i == 10'h1f7 |=> rdata_o == 8'h00)
        else $error("upper done byte not zero");
    a_done_two_lanes: assert property (rd_i && addr_i == 10'h1f6 |=> rdata_o[7:2] == 6'h00)
        else $error("done byte has bits beyond two lanes");
    a_done_new_run: assert property (rd_i && addr_i == 10'h1f6 && age_r >= 6'd4 && age_r <= 6'd40
        |=> rdata_o[1:0] == 2'b00) else $error("done flag not cleared by new run");
    a_phase_follow: assert property (p_follow_ph)
        else $error("phase offset output does not follow register");
    a_phase_cause: assert property ($changed(phase_shift_o)
        |-> $past(wr_i, 2) && $past(addr_i, 2) == 10'h1f2) else $error("phase offset changed alone");
    a_thresh_follow: assert property (p_follow_th)
        else $error("threshold output does not follow register");
    c_run: cover property (run_up);
    c_done: cover property (rd_i && addr_i == 10'h1f6 ##1 rdata_o[1:0] != 2'b00);
    c_wipe: cover property (wr_i && addr_i == 10'h1f5 && !wdata_i[0] && shd_r[5][0]);
endmodule

bind esc_top esc_top_chk i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .data_bit_i(data_bit_i), .scan_bit_i(scan_bit_i),
    .phase_shift_o(phase_shift_o), .thresh_shift_o(thresh_shift_o)
);

// ---- sim/esc_tx_model.sv ----
// Behavioural far-end transmitter feeding both samplers of the two lanes.
`timescale 1ns/1ps
module esc_tx_model (
    // Clock
    input wire clk_i,
    // Pattern level
    input wire pol_i,
    // Sampler bits
    output logic [1:0] data_bit_o = 2'b00,
    output logic [1:0] scan_bit_o = 2'b00
);
    // Lane 0 scan sampler sits past the eye edge and sees the opposite level.
    // Lane 1 scan sampler sits inside the eye and agrees with the data sampler.
    always @(posedge clk_i) begin
        data_bit_o <= {pol_i, pol_i};
        scan_bit_o <= {pol_i, ~pol_i};
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench: register access, scan modes, lengths, slots and tally wipe.
`timescale 1ns/1ps
`include "esc_regs.vh"
module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [9:0] addr_i = 10'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pol = 1'b1;
    logic [7:0] rdata_o;
    logic [1:0] data_bit, scan_bit;
    logic [6:0] phase_shift_o;
    logic [5:0] thresh_shift_o;
    logic [15:0] rd_v, t16;
    logic [3:0] srch [0:5] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
    int n_fail = 0;
    int total_checks = 0;
    esc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_bit_i(data_bit),
        .scan_bit_i(scan_bit), .phase_shift_o(phase_shift_o), .thresh_shift_o(thresh_shift_o));
    esc_tx_model i_tx (.clk_i(clk_i), .pol_i(pol), .data_bit_o(data_bit), .scan_bit_o(scan_bit));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rd_v = {8'h00, rdata_o};
    endtask
    task automatic tally(input logic ln);
        logic [7:0] lo;
        rd(`ESC_OFF_TALLY_LO + {8'h00, ln, 1'b0});
        lo = rd_v[7:0];
        rd(`ESC_OFF_TALLY_LO + {8'h00, ln, 1'b1});
        t16 = {rd_v[7:0], lo};
    endtask
    // Runs one scan from a stopped state; lanes not in care are ignored.
    task automatic scan(input logic [3:0] md, input logic [1:0] lc, input logic p,
        input logic [4:0] sl, input logic [1:0] care, input logic [1:0] dn,
        input logic [15:0] t0, input logic [15:0] t1);
        int lim;
        lim = (lc == 2'd0 ? 127 : 1032) * 11 + 100;
        wr(`ESC_OFF_RUN, 8'h00);
        // Tallies only clear on a wipe, so every scan starts from a wiped count.
        wr(`ESC_OFF_WIPE, 8'h01);
        wr(`ESC_OFF_WIPE, 8'h00);
        wr(`ESC_OFF_SETUP, {2'b00, lc, md});
        wr(`ESC_OFF_SLOT, {3'b000, sl});
        pol <= p;
        wr(`ESC_OFF_RUN, 8'h01);
        repeat (4) @(posedge clk_i);
        rd(`ESC_OFF_DONE_LO);
        chk(rd_v, 16'h0000);
        for (int i = 0; i < lim; i++) begin
            rd(`ESC_OFF_DONE_LO);
            if (dn != 2'b00 && (rd_v[1:0] & care) == dn)
                break;
        end
        chk({14'h0000, rd_v[1:0] & care}, {14'h0000, dn});
        for (int l = 0; l < 2; l++) begin
            if (dn[l]) begin
                tally(l[0]);
                chk(t16, l == 0 ? t0 : t1);
            end
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int a = 0; a < 8; a++) begin
            rd(`ESC_OFF_RUN + 10'(a));
            chk(rd_v, 16'h0000);
        end
        for (int k = 0; k < 2; k++) begin
            wr(`ESC_OFF_PHASE, k == 0 ? 8'hc0 : 8'h3f);
            wr(`ESC_OFF_THRESH, k == 0 ? 8'h20 : 8'h1f);
            repeat (2) @(posedge clk_i);
            #1;
            chk({9'h000, phase_shift_o}, k == 0 ? 16'h0040 : 16'h003f);
            chk({10'h000, thresh_shift_o}, k == 0 ? 16'h0020 : 16'h001f);
        end
        wr(10'h3ff, 8'hff);
        rd(10'h3ff);
        chk(rd_v, 16'h0000);
        scan(`ESC_MODE_CMP, 2'd0, 1'b1, 5'd0, 2'b11, 2'b11, `ESC_LEN0, 16'd0);
        scan(`ESC_MODE_ONES, 2'd0, 1'b1, 5'd19, 2'b11, 2'b11, 16'd0, `ESC_LEN0);
        scan(`ESC_MODE_CMP0, 2'd0, 1'b0, 5'd3, 2'b10, 2'b10, 16'd0, 16'd0);
        scan(`ESC_MODE_CMP1, 2'd0, 1'b0, 5'd3, 2'b10, 2'b00, 16'd0, 16'd0);
        scan(`ESC_MODE_CMP1, 2'd0, 1'b1, 5'd3, 2'b10, 2'b10, 16'd0, 16'd0);
        scan(`ESC_MODE_OFF, 2'd0, 1'b1, 5'd0, 2'b11, 2'b00, 16'd0, 16'd0);
        scan(`ESC_MODE_CMP, 2'd0, 1'b1, 5'd20, 2'b11, 2'b00, 16'd0, 16'd0);
        scan(`ESC_MODE_CMP, 2'd1, 1'b1, 5'd0, 2'b11, 2'b11, `ESC_LEN1, 16'd0);
        wr(`ESC_OFF_WIPE, 8'h01);
        wr(`ESC_OFF_WIPE, 8'h00);
        tally(1'b0);
        chk(t16, 16'h0000);
        wr(`ESC_OFF_RUN, 8'h00);
        wr(`ESC_OFF_THRESH, 8'h05);
        for (int m = 0; m < 6; m++) begin
            wr(`ESC_OFF_RUN, 8'h00);
            wr(`ESC_OFF_SETUP, {4'h0, srch[m]});
            wr(`ESC_OFF_RUN, 8'h01);
            repeat (100) @(posedge clk_i);
            #1;
            chk({10'h000, thresh_shift_o}, 16'h0020);
        end
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end
endmodule
